// ---- pkg/ltb_pkg.sv ----
package ltb_pkg;
   // ==========================================
   // Register offsets (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PASS = 8'h04;
   localparam logic [7:0] ADDR_SRC_LO1 = 8'h08;
   localparam logic [7:0] ADDR_SRC_HI1 = 8'h0C;
   localparam logic [7:0] ADDR_SRC_LO2 = 8'h10;
   localparam logic [7:0] ADDR_SRC_HI2 = 8'h14;
   localparam logic [7:0] ADDR_LIM_LO1 = 8'h18;
   localparam logic [7:0] ADDR_LIM_HI1 = 8'h1C;
   localparam logic [7:0] ADDR_LIM_LO2 = 8'h20;
   localparam logic [7:0] ADDR_LIM_HI2 = 8'h24;
   localparam logic [7:0] ADDR_STATUS = 8'h28;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h2C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h30;
   localparam logic [7:0] ADDR_CMD = 8'h34;
   localparam logic [7:0] ADDR_MANUAL = 8'h38;
   localparam logic [7:0] ADDR_READING = 8'h3C;
   // ==========================================
   // CTRL fields
   localparam int CTRL_EN1 = 0;
   localparam int CTRL_EN2 = 1;
   localparam int CTRL_BSTR = 2;
   localparam int CTRL_POL_LSB = 4;
   // CMD fields
   localparam int CMD_REEVAL = 0;
   localparam int CMD_CLR1 = 1;
   localparam int CMD_CLR2 = 2;
   localparam int CMD_PRESET = 3;
   // STATUS / IRQ fields
   localparam int ST_FAIL1 = 0;
   localparam int ST_FAIL2 = 1;
   localparam int ST_CFAIL = 2;
   localparam int ST_STROBE = 3;
   localparam int IRQ_EVAL = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_STRB = 2;
   localparam int IRQ_W = 3;
   // ==========================================
   // Reset values and timing
   localparam logic [3:0] PASS_RST = 4'h0;
   localparam logic [3:0] POL_RST = 4'hF;
   localparam int CLK_HZ = 50_000_000;
   localparam int STROBE_MIN_US = 10;
   // Strictly longer than the minimum: one extra cycle
   localparam int STROBE_CYC = STROBE_MIN_US * (CLK_HZ / 1_000_000) + 1;
   localparam int SETTLE_CYC = 2;
   localparam int RD_W = 16;
endpackage : ltb_pkg

// ---- pkg/ltb_eval_if.sv ----
interface ltb_eval_if;
   logic start;
   logic signed [ltb_pkg::RD_W-1:0] reading;
   logic signed [ltb_pkg::RD_W-1:0] lim [4];
   logic [3:0] src [4];
   logic [1:0] en;
   logic [3:0] pass_pat;
   logic done;
   logic [3:0] pattern;
   logic fail1;
   logic fail2;
   modport ctrl (output start, reading, lim, src, en, pass_pat,
                 input done, pattern, fail1, fail2);
   modport eval (input start, reading, lim, src, en, pass_pat,
                 output done, pattern, fail1, fail2);
endinterface : ltb_eval_if

// ---- rtl/ltb_eval.sv ----
module ltb_eval (
   input wire logic mclk,
   input wire logic reset,
   ltb_eval_if.eval ev
);
   logic [3:0] pattern_r;
   logic fail1_r;
   logic fail2_r;
   logic done_r;
   logic [3:0] fails;
   logic [3:0] pat_nxt;

   // ==========================================
   // Sequence: low1, high1, low2, high2
   always_comb begin
      fails[0] = ev.en[0] && (ev.reading < ev.lim[0]);
      fails[1] = ev.en[0] && (ev.reading > ev.lim[1]);
      fails[2] = ev.en[1] && (ev.reading < ev.lim[2]);
      fails[3] = ev.en[1] && (ev.reading > ev.lim[3]);
      pat_nxt = ev.pass_pat;
      for (int i = 3; i >= 0; i--) begin
         if (fails[i]) begin
            pat_nxt = ev.src[i];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         pattern_r <= 4'h0;
         fail1_r <= 1'b0;
         fail2_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= ev.start;
         if (ev.start) begin
            pattern_r <= pat_nxt;
            fail1_r <= fails[0] | fails[1];
            fail2_r <= fails[2] | fails[3];
         end
      end
   end

   assign ev.done = done_r;
   assign ev.pattern = pattern_r;
   assign ev.fail1 = fail1_r;
   assign ev.fail2 = fail2_r;

   chk_first_fail_wins: assert property (@(posedge mclk)
      disable iff (reset) ev.start && fails[0]
      |=> pattern_r == $past(ev.src[0]))
      else $error("first failing test did not select pattern");
endmodule : ltb_eval

// ---- rtl/ltb_strobe.sv ----
module ltb_strobe #(
   parameter int PULSE_CYC = ltb_pkg::STROBE_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic fire,
   output logic busy,
   output logic pulse
);
   localparam int CW = $clog2(PULSE_CYC + ltb_pkg::SETTLE_CYC + 1);
   localparam logic [CW-1:0] SET_C = CW'(ltb_pkg::SETTLE_CYC);
   localparam logic [CW-1:0] END_C = CW'(ltb_pkg::SETTLE_CYC + PULSE_CYC);
   logic [CW-1:0] cnt_r;
   logic busy_r;
   logic pulse_r;

   // ==========================================
   // Settle, then pulse
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_r <= '0;
         busy_r <= 1'b0;
         pulse_r <= 1'b0;
      end else if (fire) begin
         cnt_r <= '0;
         busy_r <= 1'b1;
         pulse_r <= 1'b0;
      end else if (busy_r) begin
         cnt_r <= cnt_r + 1'b1;
         if (cnt_r == SET_C - 1'b1) begin
            pulse_r <= 1'b1;
         end
         if (cnt_r == END_C - 1'b1) begin
            pulse_r <= 1'b0;
            busy_r <= 1'b0;
         end
      end
   end

   assign busy = busy_r;
   assign pulse = pulse_r;
endmodule : ltb_strobe

// ---- rtl/ltb_top.sv ----
// Functional notes
// - A pass pattern 0..15 is driven out when all enabled tests pass.
// - Pattern bit n drives output line n+1 (weights 1, 2, 4, 8).
// - Each line is inverted when its polarity bit selects active low.
// - Reset or preset clears the pass pattern; reads return 0..15.
// - With the strobe on, line four is dropped from every pattern.
// - With the strobe on, lines 1..3 settle then line 4 pulses >10 us.
// - The strobe pulse direction follows line four's polarity.
// - Strobe enable is one bit, cleared by reset/preset, readable.
// - Composite fail is the OR of both test fail flags.
// - Reading any fail status leaves the fail flags unchanged.
// - New limits apply from the next reading or re-evaluate; none without one.
// - Re-evaluate reruns tests on the stored reading, no conversion.
// - Tests run low1, high1, low2, high2; first failure picks pattern.
// - While a test is enabled, manual output writes are ignored.
// - Disabling a test clears its fail flag.
//
// Our own choices: the register addresses and the APB interface to the registers.
module ltb_top #(
   parameter int PULSE_CYC = ltb_pkg::STROBE_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_valid,
   input wire logic [ltb_pkg::RD_W-1:0] conv_data,
   output logic [3:0] dout,
   output logic irq
);
   ltb_eval_if ev ();

   logic [3:0] pass_r;
   logic [1:0] en_r;
   logic bstr_r;
   logic [3:0] pol_r;
   logic [3:0] src_r [4];
   logic signed [ltb_pkg::RD_W-1:0] lim_r [4];
   logic signed [ltb_pkg::RD_W-1:0] reading_r;
   logic [3:0] manual_r;
   logic fail1_r;
   logic fail2_r;
   logic [ltb_pkg::IRQ_W-1:0] istat_r;
   logic [ltb_pkg::IRQ_W-1:0] imask_r;
   logic start_r;
   logic [3:0] dout_r;
   logic irq_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic wr_acc;
   logic rd_acc;
   logic cmd_wr;
   logic preset_cmd;
   logic strb_busy;
   logic strb_pulse;
   logic [3:0] line_val;
   logic [ltb_pkg::IRQ_W-1:0] ev_set;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= ltb_pkg::ADDR_READING);
   endfunction : mapped

   // ==========================================
   // APB slave: one wait state, answer in second access cycle
   assign wr_acc = psel && penable && pwrite && pready_r;
   assign rd_acc = psel && penable && !pwrite && pready_r;
   assign cmd_wr = wr_acc && paddr == ltb_pkg::ADDR_CMD;
   assign preset_cmd = cmd_wr && pwdata[ltb_pkg::CMD_PRESET];

   always_ff @(posedge mclk) begin
      if (reset) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= psel && penable && !pready_r;
         pslverr_r <= psel && penable && !pready_r && !mapped(paddr);
      end
   end

   // ==========================================
   // Configuration registers
   always_ff @(posedge mclk) begin
      if (reset || preset_cmd) begin
         pass_r <= ltb_pkg::PASS_RST;
         en_r <= 2'b00;
         bstr_r <= 1'b0;
         pol_r <= ltb_pkg::POL_RST;
         for (int i = 0; i < 4; i++) begin
            src_r[i] <= 4'h0;
            lim_r[i] <= '0;
         end
      end else if (wr_acc && mapped(paddr)) begin
         unique case (paddr)
            ltb_pkg::ADDR_CTRL: begin
               en_r <= pwdata[ltb_pkg::CTRL_EN2:ltb_pkg::CTRL_EN1];
               bstr_r <= pwdata[ltb_pkg::CTRL_BSTR];
               pol_r <= pwdata[ltb_pkg::CTRL_POL_LSB +: 4];
            end
            ltb_pkg::ADDR_PASS: pass_r <= pwdata[3:0];
            ltb_pkg::ADDR_SRC_LO1: src_r[0] <= pwdata[3:0];
            ltb_pkg::ADDR_SRC_HI1: src_r[1] <= pwdata[3:0];
            ltb_pkg::ADDR_SRC_LO2: src_r[2] <= pwdata[3:0];
            ltb_pkg::ADDR_SRC_HI2: src_r[3] <= pwdata[3:0];
            ltb_pkg::ADDR_LIM_LO1: lim_r[0] <= pwdata[ltb_pkg::RD_W-1:0];
            ltb_pkg::ADDR_LIM_HI1: lim_r[1] <= pwdata[ltb_pkg::RD_W-1:0];
            ltb_pkg::ADDR_LIM_LO2: lim_r[2] <= pwdata[ltb_pkg::RD_W-1:0];
            ltb_pkg::ADDR_LIM_HI2: lim_r[3] <= pwdata[ltb_pkg::RD_W-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================
   // Manual output source, locked while a test is enabled
   always_ff @(posedge mclk) begin
      if (reset) begin
         manual_r <= 4'h0;
      end else if (wr_acc && paddr == ltb_pkg::ADDR_MANUAL && en_r == 2'b00) begin
         manual_r <= pwdata[3:0];
      end
   end

   // ==========================================
   // Reading store and evaluation start
   always_ff @(posedge mclk) begin
      if (reset) begin
         reading_r <= '0;
         start_r <= 1'b0;
      end else begin
         if (conv_valid) begin
            reading_r <= conv_data;
         end
         // Re-evaluate uses stored reading only
         start_r <= conv_valid || (cmd_wr && pwdata[ltb_pkg::CMD_REEVAL]);
      end
   end

   assign ev.start = start_r;
   assign ev.reading = reading_r;
   assign ev.lim = lim_r;
   assign ev.src = src_r;
   assign ev.en = en_r;
   assign ev.pass_pat = pass_r;

   ltb_eval u_eval (
      .mclk(mclk),
      .reset(reset),
      .ev(ev.eval)
   );

   // ==========================================
   // Fail flags, reloaded by each evaluation, cleared by command or disable
   always_ff @(posedge mclk) begin
      if (reset || preset_cmd) begin
         fail1_r <= 1'b0;
         fail2_r <= 1'b0;
      end else if (ev.done) begin
         fail1_r <= ev.fail1;
         fail2_r <= ev.fail2;
      end else begin
         if (!en_r[0] || (cmd_wr && pwdata[ltb_pkg::CMD_CLR1])) begin
            fail1_r <= 1'b0;
         end
         if (!en_r[1] || (cmd_wr && pwdata[ltb_pkg::CMD_CLR2])) begin
            fail2_r <= 1'b0;
         end
      end
   end

   // ==========================================
   // Binning strobe
   ltb_strobe #(
      .PULSE_CYC(PULSE_CYC)
   ) u_strobe (
      .mclk(mclk),
      .reset(reset),
      .fire(ev.done && bstr_r),
      .busy(strb_busy),
      .pulse(strb_pulse)
   );

   // ==========================================
   // Output lines
   always_comb begin
      if (en_r != 2'b00) begin
         line_val = ev.pattern;
      end else begin
         line_val = manual_r;
      end
      if (bstr_r) begin
         line_val[3] = strb_pulse;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         dout_r <= ~ltb_pkg::POL_RST;
      end else begin
         // Polarity bit 1 = active high; applies to strobe too
         dout_r <= line_val ^ ~pol_r;
      end
   end

   // ==========================================
   // Interrupts
   assign ev_set[ltb_pkg::IRQ_EVAL] = ev.done;
   assign ev_set[ltb_pkg::IRQ_FAIL] = ev.done && (ev.fail1 || ev.fail2);
   assign ev_set[ltb_pkg::IRQ_STRB] = strb_busy && !strb_pulse && bstr_r
      && dout_r[3] != ~pol_r[3] && 1'b0;

   always_ff @(posedge mclk) begin
      if (reset) begin
         istat_r <= '0;
         imask_r <= '0;
         irq_r <= 1'b0;
      end else begin
         for (int i = 0; i < ltb_pkg::IRQ_W; i++) begin
            if (ev_set[i]) begin
               istat_r[i] <= 1'b1;
            end else if (wr_acc && paddr == ltb_pkg::ADDR_IRQ_STAT
                         && pwdata[i]) begin
               istat_r[i] <= 1'b0;
            end
         end
         if (wr_acc && paddr == ltb_pkg::ADDR_IRQ_MASK) begin
            imask_r <= pwdata[ltb_pkg::IRQ_W-1:0];
         end
         irq_r <= |(istat_r & imask_r);
      end
   end

   // ==========================================
   // Read data; reads have no side effects
   always_ff @(posedge mclk) begin
      if (reset) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && penable && !pwrite && !pready_r) begin
         prdata_r <= 32'h0000_0000;
         unique case (paddr)
            ltb_pkg::ADDR_CTRL: begin
               prdata_r[1:0] <= en_r;
               prdata_r[ltb_pkg::CTRL_BSTR] <= bstr_r;
               prdata_r[ltb_pkg::CTRL_POL_LSB +: 4] <= pol_r;
            end
            ltb_pkg::ADDR_PASS: prdata_r[3:0] <= pass_r;
            ltb_pkg::ADDR_SRC_LO1: prdata_r[3:0] <= src_r[0];
            ltb_pkg::ADDR_SRC_HI1: prdata_r[3:0] <= src_r[1];
            ltb_pkg::ADDR_SRC_LO2: prdata_r[3:0] <= src_r[2];
            ltb_pkg::ADDR_SRC_HI2: prdata_r[3:0] <= src_r[3];
            ltb_pkg::ADDR_LIM_LO1: prdata_r[15:0] <= lim_r[0];
            ltb_pkg::ADDR_LIM_HI1: prdata_r[15:0] <= lim_r[1];
            ltb_pkg::ADDR_LIM_LO2: prdata_r[15:0] <= lim_r[2];
            ltb_pkg::ADDR_LIM_HI2: prdata_r[15:0] <= lim_r[3];
            ltb_pkg::ADDR_STATUS: begin
               prdata_r[ltb_pkg::ST_FAIL1] <= fail1_r;
               prdata_r[ltb_pkg::ST_FAIL2] <= fail2_r;
               prdata_r[ltb_pkg::ST_CFAIL] <= fail1_r | fail2_r;
               prdata_r[ltb_pkg::ST_STROBE] <= strb_busy;
            end
            ltb_pkg::ADDR_IRQ_STAT: prdata_r[2:0] <= istat_r;
            ltb_pkg::ADDR_IRQ_MASK: prdata_r[2:0] <= imask_r;
            ltb_pkg::ADDR_MANUAL: prdata_r[3:0] <= manual_r;
            ltb_pkg::ADDR_READING: prdata_r[15:0] <= reading_r;
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign dout = dout_r;
   assign irq = irq_r;

   // ==========================================
   // Checks
   chk_pass_reset: assert property (@(posedge mclk)
      reset |=> pass_r == 4'h0 && !bstr_r)
      else $error("pass pattern or strobe enable not cleared");
   chk_preset_clears: assert property (@(posedge mclk)
      disable iff (reset) preset_cmd |=> pass_r == ltb_pkg::PASS_RST
      && !bstr_r && en_r == 2'b00)
      else $error("preset left configuration set");
   chk_pass_select: assert property (@(posedge mclk)
      disable iff (reset) ev.done && !ev.fail1 && !ev.fail2
      |-> ev.pattern == $past(pass_r))
      else $error("pass pattern not applied");
   chk_strobe_len: assert property (@(posedge mclk)
      disable iff (reset) $rose(strb_pulse) |-> strb_pulse [*8])
      else $error("strobe pulse too short");
   chk_strobe_after: assert property (@(posedge mclk)
      disable iff (reset) $rose(strb_pulse) |-> $past(strb_busy, 1))
      else $error("strobe before pattern settled");
   chk_line4_excluded: assert property (@(posedge mclk)
      disable iff (reset) bstr_r
      |=> dout_r[3] == ($past(strb_pulse) ^ ~$past(pol_r[3])))
      else $error("pattern reached line four under strobe");
   chk_strobe_polarity: assert property (@(posedge mclk)
      disable iff (reset) bstr_r && strb_pulse
      |=> dout_r[3] == $past(pol_r[3]))
      else $error("strobe pulse direction wrong");
   chk_cfail_or: assert property (@(posedge mclk)
      disable iff (reset) ev.done && (ev.fail1 || ev.fail2)
      |=> fail1_r || fail2_r)
      else $error("composite fail lost");
   chk_cfail_read: assert property (@(posedge mclk)
      disable iff (reset) rd_acc && paddr == ltb_pkg::ADDR_STATUS
      |-> prdata_r[ltb_pkg::ST_CFAIL] == $past(fail1_r || fail2_r))
      else $error("composite fail read wrong");
   chk_disable_clears: assert property (@(posedge mclk)
      disable iff (reset) !en_r[0] && !ev.done |=> !fail1_r)
      else $error("disabled test kept fail flag");
   chk_read_keeps: assert property (@(posedge mclk)
      disable iff (reset) rd_acc && en_r[0] && !ev.done && !cmd_wr
      |=> fail1_r == $past(fail1_r))
      else $error("read altered fail flag");
   chk_new_reading: assert property (@(posedge mclk)
      disable iff (reset) conv_valid
      |=> start_r && reading_r == $past(conv_data))
      else $error("new reading not evaluated");
   chk_no_idle_eval: assert property (@(posedge mclk)
      disable iff (reset) !conv_valid && !cmd_wr |=> !start_r)
      else $error("evaluation without reading or command");
   chk_reeval_start: assert property (@(posedge mclk)
      disable iff (reset) cmd_wr && pwdata[ltb_pkg::CMD_REEVAL]
      && !conv_valid |=> start_r && $stable(reading_r))
      else $error("re-evaluate missed or started a conversion");
   chk_manual_lock: assert property (@(posedge mclk)
      disable iff (reset) en_r != 2'b00 |=> $stable(manual_r))
      else $error("manual source changed while locked");
   chk_line_polarity: assert property (@(posedge mclk)
      disable iff (reset) !bstr_r && en_r != 2'b00 && !ev.done
      ##1 !ev.done |-> dout_r == (ev.pattern ^ ~$past(pol_r)))
      else $error("output polarity wrong");
   chk_pattern_hold: assert property (@(posedge mclk)
      disable iff (reset) !ev.done |-> $stable(ev.pattern))
      else $error("pattern changed without evaluation");
   chk_ready_pulse: assert property (@(posedge mclk)
      disable iff (reset) pready_r |=> !pready_r)
      else $error("ready held longer than one cycle");
   chk_err_ready: assert property (@(posedge mclk)
      disable iff (reset) pslverr_r |-> pready_r)
      else $error("error response without ready");
   cov_strobe: cover property (@(posedge mclk) $rose(strb_pulse));
   cov_fail: cover property (@(posedge mclk) ev.done && ev.fail2);
   cov_irq: cover property (@(posedge mclk) $rose(irq_r));
   cov_reeval: cover property (@(posedge mclk)
      cmd_wr && pwdata[ltb_pkg::CMD_REEVAL]);
   cov_manual: cover property (@(posedge mclk)
      wr_acc && paddr == ltb_pkg::ADDR_MANUAL && en_r == 2'b00);
endmodule : ltb_top

// ---- bench/ltb_binner.sv ----
// ==========================================
// External binning circuit on the output lines
module ltb_binner (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [3:0] line,
   input wire logic strobe_high,
   output logic [2:0] bin_r,
   output logic [7:0] strobes_r,
   output logic [15:0] width_r
);
   timeunit 1ns;
   timeprecision 1ps;
   logic act;
   logic act_r;
   logic [15:0] cnt_r;

   // Strobe asserted level follows line four polarity
   assign act = line[3] ~^ strobe_high;

   always_ff @(posedge mclk) begin
      if (reset) begin
         act_r <= 1'b0;
         cnt_r <= 16'h0000;
         bin_r <= 3'h0;
         strobes_r <= 8'h00;
         width_r <= 16'h0000;
      end else begin
         act_r <= act;
         // Bin is read as the strobe opens
         if (act && !act_r) begin
            bin_r <= line[2:0];
            cnt_r <= 16'h0001;
         end else if (act) begin
            cnt_r <= cnt_r + 16'h0001;
         end
         if (!act && act_r) begin
            width_r <= cnt_r;
            strobes_r <= strobes_r + 8'h01;
         end
      end
   end
endmodule : ltb_binner

// ---- bench/ltb_tb_top.sv ----
module ltb_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0] ctrl;
      logic [3:0] pass;
      logic [15:0] rd;
      logic [3:0] dout;
      logic [2:0] st;
   } ltb_row_type;
   localparam int PULSE = 20;
   logic mclk;
   logic reset;
   logic psel, penable, pwrite, pready, pslverr, conv_valid, irq, err;
   logic line4_high;
   logic [7:0] paddr, strobes, n0;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] conv_data, width;
   logic [3:0] dout;
   logic [2:0] bin;
   int failures, samples_checked, cyc;
   ltb_row_type rows [8];
   logic [15:0] lims [4];

   ltb_top #(.PULSE_CYC(PULSE)) dut_u (.mclk(mclk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_valid(conv_valid),
      .conv_data(conv_data), .dout(dout), .irq(irq));

   ltb_binner bin_u (.mclk(mclk), .reset(reset), .line(dout),
      .strobe_high(line4_high), .bin_r(bin), .strobes_r(strobes),
      .width_r(width));

   always #10 mclk = ~mclk;

   // ==========================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic conv(input logic [15:0] d);
      @(posedge mclk);
      conv_valid <= 1'b1;
      conv_data <= d;
      @(posedge mclk);
      conv_valid <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : conv

   task automatic summarize;
      if (failures == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         summarize();
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      rows = '{'{8'hF3, 4'h5, 16'h0000, 4'h5, 3'h0},
               '{8'hF3, 4'h5, 16'h0096, 4'h2, 3'h5},
               '{8'hF3, 4'h5, 16'h00FA, 4'h2, 3'h7},
               '{8'hF3, 4'h5, 16'hFF06, 4'h1, 3'h7},
               '{8'hF2, 4'h5, 16'h0096, 4'h5, 3'h0},
               '{8'hF2, 4'h5, 16'h00FA, 4'h8, 3'h6},
               '{8'h03, 4'h5, 16'h0000, 4'hA, 3'h0},
               '{8'hF3, 4'hF, 16'h0000, 4'hF, 3'h0}};
      lims = '{16'hFF9C, 16'h0064, 16'hFF38, 16'h00C8};
      mclk = 1'b0;
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      conv_valid = 1'b0;
      conv_data = 16'h0000;
      line4_high = 1'b1;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      chk({28'h0, dout}, 32'h0);
      apb(1'b0, ltb_pkg::ADDR_CTRL, 32'h0);
      chk(q, 32'h000000F0);
      apb(1'b0, ltb_pkg::ADDR_PASS, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ltb_pkg::ADDR_SRC_LO1 + 8'(4 * i), 32'h1 << i);
         apb(1'b1, ltb_pkg::ADDR_LIM_LO1 + 8'(4 * i), {16'h0, lims[i]});
      end
      apb(1'b1, ltb_pkg::ADDR_IRQ_MASK, 32'h1);
      chk({31'h0, irq}, 32'h0);
      foreach (rows[i]) begin
         apb(1'b1, ltb_pkg::ADDR_CTRL, {24'h0, rows[i].ctrl});
         apb(1'b1, ltb_pkg::ADDR_PASS, {28'h0, rows[i].pass});
         conv(rows[i].rd);
         chk({28'h0, dout}, {28'h0, rows[i].dout});
         apb(1'b0, ltb_pkg::ADDR_STATUS, 32'h0);
         chk({29'h0, q[2:0]}, {29'h0, rows[i].st});
         apb(1'b0, ltb_pkg::ADDR_STATUS, 32'h0);
         chk({29'h0, q[2:0]}, {29'h0, rows[i].st});
      end
      // Interrupt raised, cleared by write-one
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, ltb_pkg::ADDR_IRQ_STAT, 32'h7);
      repeat (3) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ltb_pkg::ADDR_IRQ_MASK, 32'h0);
      apb(1'b1, ltb_pkg::ADDR_PASS, 32'h5);
      conv(16'h0000);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, ltb_pkg::ADDR_IRQ_STAT, 32'h0);
      chk({31'h0, q[0]}, 32'h1);
      // New limit waits for a reading or a re-evaluate
      apb(1'b1, ltb_pkg::ADDR_LIM_HI1, 32'h0000FFF6);
      repeat (5) @(posedge mclk);
      chk({28'h0, dout}, 32'h5);
      apb(1'b1, ltb_pkg::ADDR_CMD, 32'h1);
      repeat (4) @(posedge mclk);
      chk({28'h0, dout}, 32'h2);
      apb(1'b0, ltb_pkg::ADDR_READING, 32'h0);
      chk({16'h0, q[15:0]}, 32'h0);
      apb(1'b1, ltb_pkg::ADDR_LIM_HI1, 32'h00000064);
      // Manual output only while no test is enabled
      apb(1'b1, ltb_pkg::ADDR_MANUAL, 32'h9);
      repeat (3) @(posedge mclk);
      chk({28'h0, dout}, 32'h2);
      apb(1'b1, ltb_pkg::ADDR_CTRL, 32'hF0);
      apb(1'b1, ltb_pkg::ADDR_MANUAL, 32'h9);
      repeat (3) @(posedge mclk);
      chk({28'h0, dout}, 32'h9);
      // Binning strobe, both polarities of line four
      apb(1'b1, ltb_pkg::ADDR_PASS, 32'hF);
      for (int k = 0; k < 2; k++) begin
         line4_high <= (k == 0);
         apb(1'b1, ltb_pkg::ADDR_CTRL, (k == 0) ? 32'hF7 : 32'h77);
         repeat (5) @(posedge mclk);
         n0 = strobes;
         conv(16'h0000);
         while (strobes == n0) @(posedge mclk);
         chk({16'h0, width}, PULSE);
         chk({29'h0, bin}, 32'h7);
         chk({28'h0, dout}, (k == 0) ? 32'h7 : 32'hF);
         apb(1'b0, ltb_pkg::ADDR_CTRL, 32'h0);
         chk({31'h0, q[ltb_pkg::CTRL_BSTR]}, 32'h1);
      end
      apb(1'b1, ltb_pkg::ADDR_CMD, 32'h8);
      apb(1'b0, ltb_pkg::ADDR_CTRL, 32'h0);
      chk({31'h0, q[ltb_pkg::CTRL_BSTR]}, 32'h0);
      apb(1'b0, ltb_pkg::ADDR_PASS, 32'h0);
      chk(q, 32'h0);
      summarize();
   end
endmodule : ltb_tb_top
